// ===== rtl/smc_pkg.sv
// Shared constants and types of the external static memory controller.
// Assumes one system clock and a synchronous, active-high reset.
package smc_pkg;

  // Bank count and system address fields.
  localparam int         NUM_BANKS = 8;
  localparam logic [2:0] EXT_BASE  = 3'h2;
  localparam int         BASE_HI   = 31;
  localparam int         BASE_LO   = 29;
  localparam int         BANK_HI   = 28;
  localparam int         BANK_LO   = 26;
  localparam int         LOC_HI    = 23;

  // External data width codes; the spare code is served as 32 bits.
  localparam logic [1:0] WID_8  = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;
  localparam logic [1:0] WID_32 = 2'h2;

  // Lanes used by each width, as active-low lane masks.
  localparam logic [3:0] LANES_8  = 4'he;
  localparam logic [3:0] LANES_16 = 4'hc;
  localparam logic [3:0] LANES_32 = 4'h0;
  localparam logic [3:0] LANES_OFF = 4'hf;

  // Default log2 of the page size in bytes for page-mode reads.
  localparam int PAGE_LOG_DEF = 4;

  // Per-bank configuration; wait fields hold cycles minus one.
  typedef struct packed {
    logic [1:0] width;
    logic       cs_high;
    logic       wprot;
    logic       burst_en;
    logic       rd_lanes;
    logic [3:0] idle;
    logic [4:0] wst_rd;
    logic [4:0] wst_wr;
    logic [4:0] wst_b_first;
    logic [4:0] wst_b_next;
  } smc_cfg_t;

  // One system request: a word with byte enables.
  typedef struct packed {
    logic [31:0] addr;
    logic        we;
    logic [3:0]  be;
    logic [31:0] wdata;
  } smc_req_t;

  // Levels driven on the external bus for one beat.
  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] dout;
    logic [3:0]  bls_n;
  } smc_pins_t;

  typedef enum logic [2:0] {S_IDLE, S_TURN, S_RD, S_WR, S_WHOLD, S_PAGE} smc_st_t;

  // State of the controller, apart from the wait counter in smc_wait_cnt.
  typedef struct packed {
    smc_st_t     st;
    smc_req_t    req;
    logic [2:0]  bank;
    logic [1:0]  beat;
    logic        last_rd;
    logic [2:0]  last_bank;
    logic [7:0]  cs;
    logic [3:0]  bls_n;
    logic        we_n;
    logic        oe_n;
    logic [23:0] addr;
    logic [31:0] dout;
    logic        doe;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } smc_state_t;

endpackage : smc_pkg

// ===== rtl/smc_dec.sv
// Address decoder of the external static memory controller.
// Assumes a 32-bit system address; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module smc_dec
  import smc_pkg::*;
(
  input  wire logic [31:0] i_addr,
  output logic             o_ext,
  output logic [2:0]       o_bank,
  output logic [23:0]      o_loc
);

  // Bits 25 and 24 are not looked at, so they mirror the bank.
  assign o_ext  = (i_addr[BASE_HI:BASE_LO] == EXT_BASE); // RULE4
  assign o_bank = i_addr[BANK_HI:BANK_LO];               // RULE5 RULE6
  assign o_loc  = i_addr[LOC_HI:0];                      // RULE7

endmodule : smc_dec
`default_nettype wire

// ===== rtl/smc_wait_cnt.sv
// Loadable down counter that times wait states and idle cycles.
// Assumes the load value is held in the cycle in which load is high.
`timescale 1ns/10ps
`default_nettype none
module smc_wait_cnt
  import smc_pkg::*;
#(
  parameter int W = 5
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  output logic              o_zero
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  if (W < 4) begin : g_chk
    $error("smc_wait_cnt: W must cover the idle field");
  end

  // Load wins; otherwise count down to zero and hold.
  always_comb begin
    next_cnt = cnt;
    if (i_reset) begin
      next_cnt = '0;
    end else if (i_load) begin
      next_cnt = i_value;
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    cnt <= next_cnt;
  end

  assign o_zero = (cnt == '0);

endmodule : smc_wait_cnt
`default_nettype wire

// ===== rtl/smc_ctrl.sv
// Top of the external static memory controller: eight banks of
// SRAM, ROM, flash, burst ROM or I/O behind one asynchronous bus.
// Assumes a requester that holds its request until acknowledged and
// a bank configuration that stays static while that bank is in use.
`timescale 1ns/10ps
`default_nettype none
// Operation
// [RULE1] Eight banks, each own configuration, 16 MB.
// [RULE2] Width 8, 16 or 32; accesses split.
// [RULE3] One chip select per bank, programmable polarity.
// [RULE4] External only when address top bits 010.
// [RULE5] Address bits 28..26 pick the bank.
// [RULE6] Bits 25..24 ignored, giving mirrors.
// [RULE7] Bits 23..0 drive the external address.
// [RULE8] Turnaround idle count one to 16 cycles.
// [RULE9] Idle cycles between read and write.
// [RULE10] Read and write waits up to 32.
// [RULE11] Burst ROM: first and subsequent waits.
// [RULE12] Page-mode reads keep the access open.
// [RULE13] Burst reads when bank burst enabled.
// [RULE14] Option for lane selects during reads.
// [RULE15] Four byte-lane select outputs.
// [RULE16] Write strobe low only while writing.
// [RULE17] Output enable low during reads.
// [RULE18] Protected banks never see the write strobe.
// [RULE19] Memory drives data only when selected.
module smc_ctrl
  import smc_pkg::*;
#(
  parameter int PAGE_LOG = PAGE_LOG_DEF
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_req_valid,
  input  wire smc_req_t             i_req,
  input  wire smc_cfg_t [NUM_BANKS-1:0] i_cfg,
  input  wire logic [31:0]          i_data_in,
  output logic [7:0]                o_bank_select,
  output logic [3:0]                o_byte_lane_select_n,
  output logic                      o_we_n,
  output logic                      o_oe_n,
  output logic [23:0]               o_addr,
  output logic [31:0]               o_data_out,
  output logic                      o_data_oe,
  output logic                      o_ack,
  output logic                      o_err,
  output logic [31:0]               o_rdata
);

  if (PAGE_LOG < 2 || PAGE_LOG > 23) begin : g_chk
    $error("smc_ctrl: PAGE_LOG must lie in 2..23");
  end

  smc_state_t r;
  smc_state_t next_r;
  smc_cfg_t   cur_cfg;
  smc_cfg_t   new_cfg;
  logic       d_ext;
  logic [2:0] d_bank;
  logic [23:0] d_loc;
  logic       take;
  logic       page_hit;
  logic       need_turn;
  logic       last_beat;
  logic       cnt_zero;
  logic       ld;
  logic [4:0] ld_val;
  logic [7:0] cs_idle;

  // Decode of the incoming request address.
  smc_dec u_dec (
    .i_addr (i_req.addr),
    .o_ext  (d_ext),
    .o_bank (d_bank),
    .o_loc  (d_loc)
  );

  // One timer serves wait states and turnaround idle cycles.
  smc_wait_cnt #(.W(5)) u_cnt (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_load    (ld),
    .i_value   (ld_val),
    .o_zero    (cnt_zero)
  );

  // Bus levels for one beat of an access, sized to the bank width.
  function automatic smc_pins_t pins(smc_cfg_t c, smc_req_t q, logic [1:0] b);
    smc_pins_t p;
    logic [3:0] unused;
    p = '0;
    unused = LANES_32;
    unique case (c.width)
      WID_8: begin // RULE2
        p.addr = {q.addr[23:2], b};
        p.dout = {24'h0, q.wdata[{b, 3'h0} +: 8]};
        p.bls_n = {3'h7, ~q.be[b]};
        unused = LANES_8;
      end
      WID_16: begin // RULE2
        p.addr = {q.addr[23:2], b[0], 1'b0};
        p.dout = {16'h0, q.wdata[{b[0], 4'h0} +: 16]};
        p.bls_n = {2'h3, ~q.be[{b[0], 1'b1}], ~q.be[{b[0], 1'b0}]};
        unused = LANES_16;
      end
      default: begin
        p.addr = {q.addr[23:2], 2'h0}; // RULE7
        p.dout = q.wdata;
        p.bls_n = ~q.be; // RULE15
      end
    endcase
    // Reads drive the used lanes only when the bank asks for it.
    if (!q.we) begin
      p.bls_n = c.rd_lanes ? unused : LANES_OFF; // RULE14
    end
    return p;
  endfunction : pins

  // Wait count of a beat, by direction and burst position.
  function automatic logic [4:0] wait_of(smc_cfg_t c, logic we, logic first);
    logic [4:0] w;
    if (we) begin
      w = c.wst_wr; // RULE10
    end else if (c.burst_en) begin
      w = first ? c.wst_b_first : c.wst_b_next; // RULE11 RULE13
    end else begin
      w = c.wst_rd; // RULE10
    end
    return w;
  endfunction : wait_of

  // Places a beat on the bus: select, strobes, address and data.
  function automatic smc_state_t launch(smc_state_t s, smc_cfg_t c, logic [7:0] ci);
    smc_pins_t p;
    p = pins(c, s.req, s.beat);
    s.addr = p.addr;
    s.dout = p.dout;
    s.bls_n = p.bls_n;
    s.cs = ci;
    s.cs[s.bank] = c.cs_high; // RULE3
    s.we_n = ~s.req.we; // RULE16
    s.oe_n = s.req.we;  // RULE17
    s.doe = s.req.we;
    s.st = s.req.we ? S_WR : S_RD;
    return s;
  endfunction : launch

  // Idle select levels follow each bank's polarity.
  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      cs_idle[i] = ~i_cfg[i].cs_high; // RULE1 RULE3
    end
  end

  // Request acceptance and decisions on the open access.
  always_comb begin
    cur_cfg = i_cfg[r.bank];
    new_cfg = i_cfg[d_bank];
    take = i_req_valid && !r.ack && (r.st == S_IDLE || r.st == S_PAGE);
    page_hit = (r.st == S_PAGE) && !i_req.we && (d_bank == r.bank)
               && (d_loc[23:PAGE_LOG] == r.req.addr[23:PAGE_LOG]); // RULE12
    need_turn = r.last_rd && ((i_req.we && d_bank == r.last_bank)
                || d_bank != r.last_bank); // RULE9
    unique case (cur_cfg.width)
      WID_8:   last_beat = (r.beat == 2'h3);
      WID_16:  last_beat = (r.beat == 2'h1);
      default: last_beat = 1'b1;
    endcase
  end

  // Main sequencer.
  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    next_r.err = 1'b0;
    ld = 1'b0;
    ld_val = 5'h0;
    if (i_reset) begin
      next_r = '0;
      next_r.st = S_IDLE;
      next_r.cs = cs_idle;
      next_r.bls_n = LANES_OFF;
      next_r.we_n = 1'b1;
      next_r.oe_n = 1'b1;
    end else begin
      unique case (r.st)
        S_IDLE, S_PAGE: begin
          if (take) begin
            if (!d_ext || (i_req.we && new_cfg.wprot)) begin // RULE4 RULE18
              // Refused at once; an open page stays open.
              next_r.ack = 1'b1;
              next_r.err = 1'b1;
            end else begin
              next_r.req = i_req;
              next_r.bank = d_bank;
              next_r.beat = 2'h0;
              if (page_hit) begin
                // Page hit: select stays active and output enable stays low.
                next_r = launch(next_r, new_cfg, cs_idle); // RULE12
                ld = 1'b1;
                ld_val = wait_of(new_cfg, 1'b0, 1'b0); // RULE11
              end else if (need_turn) begin
                // Release the bus for the turnaround time.
                next_r.st = S_TURN;
                next_r.cs = cs_idle;
                next_r.oe_n = 1'b1;
                next_r.bls_n = LANES_OFF;
                ld = 1'b1;
                ld_val = {1'b0, i_cfg[r.last_bank].idle}; // RULE8 RULE9
              end else begin
                next_r = launch(next_r, new_cfg, cs_idle);
                ld = 1'b1;
                ld_val = wait_of(new_cfg, i_req.we, 1'b1);
              end
            end
          end
        end
        S_TURN: begin
          // Idle time over: start the held request.
          if (cnt_zero) begin
            next_r.last_rd = 1'b0;
            next_r = launch(next_r, cur_cfg, cs_idle);
            ld = 1'b1;
            ld_val = wait_of(cur_cfg, r.req.we, 1'b1);
          end
        end
        S_RD: begin
          if (cnt_zero) begin
            // Capture the beat into its place in the word.
            unique case (cur_cfg.width)
              WID_8:   next_r.rdata[{r.beat, 3'h0} +: 8] = i_data_in[7:0];
              WID_16:  next_r.rdata[{r.beat[0], 4'h0} +: 16] = i_data_in[15:0];
              default: next_r.rdata = i_data_in;
            endcase
            if (last_beat) begin
              next_r.ack = 1'b1;
              next_r.last_rd = 1'b1;
              next_r.last_bank = r.bank;
              if (cur_cfg.burst_en) begin
                next_r.st = S_PAGE; // RULE13
              end else begin
                next_r.st = S_IDLE;
                next_r.cs = cs_idle;
                next_r.oe_n = 1'b1;
                next_r.bls_n = LANES_OFF;
              end
            end else begin
              // Next beat of a narrow bank, timed as a follow-on.
              next_r.beat = r.beat + 2'h1; // RULE2
              next_r = launch(next_r, cur_cfg, cs_idle);
              ld = 1'b1;
              ld_val = wait_of(cur_cfg, 1'b0, 1'b0);
            end
          end
        end
        S_WR: begin
          // Write strobe rises; address, data and select hold.
          if (cnt_zero) begin
            next_r.we_n = 1'b1; // RULE16
            next_r.st = S_WHOLD;
          end
        end
        S_WHOLD: begin
          if (last_beat) begin
            next_r.ack = 1'b1;
            next_r.last_rd = 1'b0;
            next_r.st = S_IDLE;
            next_r.cs = cs_idle;
            next_r.doe = 1'b0;
            next_r.bls_n = LANES_OFF;
          end else begin
            next_r.beat = r.beat + 2'h1; // RULE2
            next_r = launch(next_r, cur_cfg, cs_idle);
            ld = 1'b1;
            ld_val = cur_cfg.wst_wr; // RULE10
          end
        end
        default: begin
          next_r.st = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    r <= next_r;
  end

  // Every output is a field of the state register.
  assign o_bank_select        = r.cs;
  assign o_byte_lane_select_n = r.bls_n;
  assign o_we_n               = r.we_n;
  assign o_oe_n               = r.oe_n;
  assign o_addr               = r.addr;
  assign o_data_out           = r.dout;
  assign o_data_oe            = r.doe;
  assign o_ack                = r.ack;
  assign o_err                = r.err;
  assign o_rdata              = r.rdata;

  // Length of the present low phase of the write strobe.
  logic [5:0] we_len;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || o_we_n) begin
      we_len <= 6'h0;
    end else begin
      we_len <= we_len + 6'h1;
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  // Exactly one bank selected while a beat is on the bus.
  property p_cs_one;
    (r.st == S_RD || r.st == S_WR) |-> $onehot(o_bank_select ^ cs_idle);
  endproperty
  a_cs_one: assert property (p_cs_one) // RULE3
    else $error("chip select not one-hot during access");

  // The select follows address bits 28 to 26, mirrors included.
  property p_bank;
    take && d_ext && !i_req.we && !page_hit && !need_turn
      |=> o_bank_select[$past(i_req.addr[28:26])] == i_cfg[r.bank].cs_high;
  endproperty
  a_bank: assert property (p_bank) // RULE5
    else $error("wrong bank selected");

  property p_we_wr;
    !o_we_n |-> r.st == S_WR && o_oe_n;
  endproperty
  a_we_wr: assert property (p_we_wr) // RULE16
    else $error("write strobe outside a write");

  property p_oe_rd;
    !o_oe_n |-> o_we_n && (r.st == S_RD || r.st == S_PAGE);
  endproperty
  a_oe_rd: assert property (p_oe_rd) // RULE17
    else $error("output enable outside a read");

  property p_nonext;
    take && !d_ext |=> o_ack && o_err && $stable(o_bank_select);
  endproperty
  a_nonext: assert property (p_nonext) // RULE4
    else $error("non-external access not refused");

  property p_wprot;
    take && d_ext && i_req.we && new_cfg.wprot |=> o_err ##1 o_we_n;
  endproperty
  a_wprot: assert property (p_wprot) // RULE18
    else $error("protected write reached the bus");

  property p_turn;
    take && d_ext && i_req.we && !new_cfg.wprot && r.last_rd
      && d_bank == r.last_bank |=> r.st == S_TURN && o_oe_n;
  endproperty
  a_turn: assert property (p_turn) // RULE9
    else $error("no idle cycles between read and write");

  property p_we_len;
    $rose(o_we_n) |-> we_len == {1'b0, i_cfg[r.bank].wst_wr} + 6'h1;
  endproperty
  a_we_len: assert property (p_we_len) // RULE10
    else $error("write strobe length differs from wait setting");

  property p_rd_lanes;
    !o_oe_n && !i_cfg[r.bank].rd_lanes |-> o_byte_lane_select_n == LANES_OFF;
  endproperty
  a_rd_lanes: assert property (p_rd_lanes) // RULE14
    else $error("lane selects driven on a read with option off");

  property p_addr;
    r.st == S_WR |-> o_addr[23:2] == r.req.addr[23:2];
  endproperty
  a_addr: assert property (p_addr) // RULE7
    else $error("external address does not follow request");

endmodule : smc_ctrl
`default_nettype wire

// ===== tb/smc_mem_model.sv
// Behavioural external asynchronous memory standing behind all eight banks.
// Assumes the controller's pins and each bank's chip-select polarity.
`timescale 1ns/10ps
`default_nettype none
module smc_mem_model (
  input  wire logic        i_ref_clk,
  input  wire logic [7:0]  i_bank_select,
  input  wire logic [7:0]  i_cs_high,
  input  wire logic [3:0]  i_byte_lane_select_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic [23:0] i_addr,
  input  wire logic [31:0] i_data,
  output logic [31:0]      o_data
);
  logic [31:0] mem [int];
  logic [31:0] last = 32'h0;
  logic [31:0] w;
  logic [7:0]  act;
  int          key;

  // A bank is selected while its pin sits at its active level.
  assign act = ~(i_bank_select ^ i_cs_high);

  // The word is keyed by selected bank and external address.
  always @* begin
    key = 0;
    for (int i = 0; i < 8; i++) if (act[i]) key = (i << 24) | int'(i_addr);
  end

  // Lanes enabled while the write strobe is low land in the word.
  always @(posedge i_ref_clk) begin
    if (act != 8'h00 && !i_we_n) begin
      w = mem.exists(key) ? mem[key] : 32'h0;
      for (int k = 0; k < 4; k++) if (!i_byte_lane_select_n[k]) w[8*k+:8] = i_data[8*k+:8];
      mem[key] = w;
    end
    last <= o_data;
  end

  // Drive only while selected and enabled; otherwise a value that flips each cycle.
  always @* begin
    if (act != 8'h00 && !i_oe_n && mem.exists(key)) o_data = mem[key];
    else o_data = ~last;
  end
endmodule : smc_mem_model
`default_nettype wire

// ===== tb/smc_ctrl_tb_top.sv
// Self-checking bench of the external static memory controller.
// Assumes the package, the design files and the memory model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module smc_ctrl_tb_top
  import smc_pkg::*;
;
  logic                     i_ref_clk, i_reset, i_req_valid, busy;
  smc_req_t                 i_req;
  smc_cfg_t [NUM_BANKS-1:0] i_cfg;
  logic [31:0]              i_data_in, o_data_out, o_rdata;
  logic [7:0]               o_bank_select, cs_high, act;
  logic [3:0]               o_byte_lane_select_n;
  logic [23:0]              o_addr;
  logic                     o_we_n, o_oe_n, o_data_oe, o_ack, o_err;
  logic [2:0]               cur;
  logic [21:0]              cur_a;
  logic [31:0]              seed = 32'h5756;
  logic [7:0]               ref_mem [int];
  int                       n_mismatch = 0;
  int                       n_compared = 0;
  int                       lat;

  smc_ctrl u_smc_ctrl (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_req_valid(i_req_valid),
    .i_req(i_req), .i_cfg(i_cfg), .i_data_in(i_data_in), .o_bank_select(o_bank_select),
    .o_byte_lane_select_n(o_byte_lane_select_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
    .o_addr(o_addr), .o_data_out(o_data_out), .o_data_oe(o_data_oe), .o_ack(o_ack),
    .o_err(o_err), .o_rdata(o_rdata));

  smc_mem_model u_smc_mem_model (.i_ref_clk(i_ref_clk), .i_bank_select(o_bank_select),
    .i_cs_high(cs_high), .i_byte_lane_select_n(o_byte_lane_select_n), .i_we_n(o_we_n),
    .i_oe_n(o_oe_n), .i_addr(o_addr), .i_data(o_data_out), .o_data(i_data_in));

  // Active-level view of the chip selects.
  always_comb begin
    for (int i = 0; i < 8; i++) cs_high[i] = i_cfg[i].cs_high;
  end
  assign act = ~(o_bank_select ^ cs_high);

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // One request held until acknowledged; lat counts cycles from the taking edge.
  task automatic acc(input logic [31:0] a, input logic w, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] rd, output logic e);
    int n;
    @(posedge i_ref_clk);
    #1;
    i_req = '{addr: a, we: w, be: be, wdata: d};
    i_req_valid = 1'b1;
    lat = 0;
    for (n = 0; n < 400 && o_ack !== 1'b1; n++) begin
      @(posedge i_ref_clk);
      #1;
      lat++;
      busy = 1'b1;
    end
    if (o_ack !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = o_rdata;
    e = o_err;
    i_req_valid = 1'b0;
    @(posedge i_ref_clk);
    #1;
    busy = 1'b0;
  endtask : acc

  // Runs one access and compares refusal and read data with the byte model.
  task automatic op(input logic [31:0] a, input logic w, input logic [3:0] be);
    logic [31:0] d, rd, exp;
    logic        e, x, full;
    int          key;
    d = rnd();
    x = (a[31:29] != EXT_BASE) || (w && i_cfg[a[28:26]].wprot);
    key = int'({a[28:26], a[23:2], 2'b00});
    // A refused request leaves an open page on the bus untouched.
    if (!x) begin
      cur = a[28:26];
      cur_a = a[23:2];
    end
    acc(a, w, be, d, rd, e);
    chk({31'h0, e}, {31'h0, x});
    if (x) chk(32'(lat), 32'h1);
    full = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (!x && w && be[k]) ref_mem[key + k] = d[8*k+:8];
      full &= ref_mem.exists(key + k) != 0;
      exp[8*k+:8] = ref_mem.exists(key + k) ? ref_mem[key + k] : 8'h0;
    end
    if (!x && !w && full) chk(rd, exp);
  endtask : op

  // Pin checks in every strobed cycle after the taking edge.
  always @(posedge i_ref_clk) begin
    if (busy && (!o_we_n || !o_oe_n)) begin
      chk({24'h0, act}, 32'h1 << cur);
      chk({10'h0, o_addr[23:2]}, {10'h0, cur_a});
      chk({31'h0, o_we_n | o_oe_n}, 32'h1);
      chk({31'h0, o_data_oe}, {31'h0, !o_we_n});
      if (i_cfg[cur].width == WID_32 && !o_we_n) chk(o_data_out, i_req.wdata);
      if (!o_we_n) chk({30'h0, i_req.we, i_cfg[cur].wprot}, 32'h2);
      if (i_cfg[cur].width == WID_32 && !o_we_n)
        chk({28'h0, o_byte_lane_select_n}, {28'h0, ~i_req.be});
      if (i_cfg[cur].width == WID_32 && !o_oe_n)
        chk({28'h0, o_byte_lane_select_n}, i_cfg[cur].rd_lanes ? 32'h0 : 32'hf);
    end
  end

  initial begin
    logic [31:0] r, a;
    i_reset = 1'b1;
    i_req_valid = 1'b0;
    i_req = '0;
    busy = 1'b0;
    cur = 3'h0;
    cur_a = '0;
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      i_cfg[i] = '0;
      i_cfg[i].width = (i == 1 || i == 5) ? WID_16 : (i == 2 || i == 6) ? WID_8 : WID_32;
      i_cfg[i].cs_high = r[0];
      i_cfg[i].rd_lanes = r[1];
      i_cfg[i].idle = r[5:2];
      i_cfg[i].wst_rd = {3'h0, r[7:6]};
      i_cfg[i].wst_wr = {3'h0, r[9:8]};
      i_cfg[i].wst_b_first = {3'h0, r[11:10]};
      i_cfg[i].burst_en = (i == 4 || i == 6);
      i_cfg[i].wprot = (i == 3);
    end
    repeat (20) @(posedge i_ref_clk);
    #1;
    i_reset = 1'b0;
    chk({act, o_byte_lane_select_n, o_we_n, o_oe_n, o_ack, o_err, o_data_oe},
        {8'h0, 4'hf, 5'h18});
    $display("test reset done");
    // Protected bank keeps its old word.
    i_cfg[3].wprot = 1'b0;
    op(32'h4c00_0010, 1'b1, 4'hf);
    i_cfg[3].wprot = 1'b1;
    op(32'h4c00_0010, 1'b1, 4'hf);
    op(32'h4c00_0010, 1'b0, 4'hf);
    $display("test write protection done");
    // Random traffic over all banks, widths, mirrors and refusals.
    repeat (150) begin
      r = rnd();
      a = {(r[10:8] == 3'h0) ? 3'h3 : EXT_BASE, r[13:11], r[15:14], 18'h0, r[19:16], 2'b00};
      op(a, r[20], r[24:21]);
    end
    $display("test random traffic done");
    // Latencies and read-to-write turnaround at both ends of the ranges.
    for (int k = 0; k < 2; k++) begin
      i_cfg[0].wst_wr = k ? 5'h1f : 5'h00;
      i_cfg[0].wst_rd = k ? 5'h1f : 5'h00;
      i_cfg[0].idle = k ? 4'hf : 4'h0;
      op(32'h4000_0040, 1'b1, 4'hf);
      op(32'h4000_0040, 1'b1, 4'h5);
      chk(32'(lat), 32'(i_cfg[0].wst_wr) + 32'h3);
      op(32'h4000_0040, 1'b0, 4'hf);
      chk(32'(lat), 32'(i_cfg[0].wst_rd) + 32'h2);
      op(32'h4000_0040, 1'b1, 4'hf);
      chk(32'(lat), 32'(i_cfg[0].wst_wr) + 32'(i_cfg[0].idle) + 32'h4);
    end
    $display("test latency done");
    tally_and_finish();
  end
endmodule : smc_ctrl_tb_top
`default_nettype wire
